/* hdl/sock_pwr_defines.svh */
// Offsets, field positions, masks and reset values of the socket power control register.
// Assumes inclusion by bare name from the register module.
`ifndef SOCK_PWR_DEFINES_SVH
`define SOCK_PWR_DEFINES_SVH

// ==========================================
// Register placement
`define SPC_OFFSET 12'h802
`define SPC_LEGACY_INDEX 8'h02

// ==========================================
// Field positions, shared and per layout
`define SPC_GATE_BIT 7
`define SPC_AUTO_BIT 5
`define SPC_CONNECT_BIT 4
`define SPC_VCC_HI 4
`define SPC_VCC_LO 3
`define SPC_VPP_HI 1
`define SPC_VPP_LO 0

// ==========================================
// Writable and sticky masks per layout
`define SPC_WMASK_LEGACY 8'hB3
`define SPC_WMASK_NEW 8'h9B
`define SPC_STICKY_LEGACY 8'h20
`define SPC_STICKY_NEW 8'h9B
`define SPC_RESET 8'h00

// ==========================================
// Field codes
`define SPC_REV_LEGACY 4'h2
`define SPC_REV_DEFAULT 4'h4
`define SPC_VCC_5V0 2'h2
`define SPC_VCC_3V3 2'h3
`define SPC_VPP_VCC 2'h1
`define SPC_VPP_12V 2'h2

`endif

/* hdl/sock_pwr_pkg.sv */
// Types of the socket power control block: supply level codes and module state.
// Assumes the defines header sits beside it.
package sock_pwr_pkg;

  // ==========================================
  // Supply levels sent to the power switch
  typedef enum logic [1:0] {VCC_OFF, VCC_5V0, VCC_3V3} vcc_level_t;
  typedef enum logic [1:0] {VPP_OFF, VPP_VCC, VPP_12V} vpp_level_t;

  // ==========================================
  // State of the reset controller
  typedef struct packed {
    logic [1:0] rst_sync; // Release shift chain
  } rst_state_t;

  // ==========================================
  // State of the register block
  typedef struct packed {
    logic [7:0] ctl; // Raw register storage
    logic [7:0] rdata; // Read data
    logic rvalid; // Read answer marker
    logic [1:0] cd1_sync; // Card detect 1 synchroniser
    logic [1:0] cd2_sync; // Card detect 2 synchroniser
    vcc_level_t sw_vcc; // Forwarded Vcc request
    vpp_level_t sw_vpp; // Forwarded Vpp request
    logic req; // New power request pulse
  } spc_state_t;

endpackage

/* hdl/sock_pwr_reset.sv */
// Reset controller: releases the global reset through two flip-flops and derives the bus-reset clears.
// Assumes bus_reset_n and pme_enable are synchronous to ref_clk.
`timescale 1ns/100ps
`default_nettype none
module sock_pwr_reset
  import sock_pwr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic bus_reset_n,
  input wire logic pme_enable,
  output logic rst_n,
  output logic plain_clr,
  output logic sticky_clr
);
  import sock_pwr_pkg::*;

  rst_state_t s; // Current state
  rst_state_t next_s; // Next state

  // ==========================================
  // Next state: shift ones in after release
  always_comb begin
    next_s = s;
    next_s.rst_sync = {s.rst_sync[0], 1'b1};
  end

  // Asynchronous assert, synchronous release
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign rst_n = s.rst_sync[1];
  // Bus reset clears ordinary bits always
  assign plain_clr = !bus_reset_n;
  // Sticky bits survive bus reset while events are enabled
  assign sticky_clr = !bus_reset_n && !pme_enable;
endmodule
`default_nettype wire

/* hdl/socket_power_control_register.sv */
// Socket power control register: storage, two field layouts, supply requests and output gating.
// Assumes a strobe-style register port on ref_clk and card detect pins from outside the clock domain.
`timescale 1ns/100ps
`default_nettype none
`include "sock_pwr_defines.svh"
module socket_power_control_register
  import sock_pwr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic bus_reset_n,
  input wire logic pme_enable,
  input wire logic [11:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic [3:0] compat_revision_field,
  input wire logic vcc_voltage_select,
  input wire logic cd1_n,
  input wire logic cd2_n,
  output logic card_output_gate,
  output logic card_drive_oe_n,
  output logic auto_power_switch_on,
  output var sock_pwr_pkg::vcc_level_t sw_vcc_level,
  output var sock_pwr_pkg::vpp_level_t sw_vpp_level,
  output logic power_request,
  output logic card_power_status
);
  import sock_pwr_pkg::*;

  // ==========================================
  // Reset controller
  logic rst_n; // Synchronised global reset
  logic plain_clr; // Bus reset clear, non-sticky bits
  logic sticky_clr; // Bus reset clear reaching sticky bits

  sock_pwr_reset u_reset (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .bus_reset_n(bus_reset_n),
    .pme_enable(pme_enable),
    .rst_n(rst_n),
    .plain_clr(plain_clr),
    .sticky_clr(sticky_clr)
  );

  // ==========================================
  // State and decode helpers
  spc_state_t s; // Current state
  spc_state_t next_s; // Next state
  logic legacy; // Legacy layout selected
  logic hit; // Register addressed
  logic [7:0] wmask; // Bits software may write
  logic [7:0] smask; // Bits kept across bus reset
  logic [7:0] view; // Register as software sees it
  logic seated; // Both card detects asserted
  vcc_level_t vcc_eff; // Vcc the settings ask for
  vpp_level_t vpp_eff; // Vpp the settings ask for

  // Layout choice from the revision field
  assign legacy = (compat_revision_field == `SPC_REV_LEGACY);
  assign hit = (reg_addr == `SPC_OFFSET);
  // Storage is shared by both layouts: bits hidden by one layout keep their value and
  // reappear after a switch, which saves a second copy but can surprise a careless driver
  // Reserved bits are neither stored by writes nor shown on reads
  assign wmask = legacy ? `SPC_WMASK_LEGACY : `SPC_WMASK_NEW;
  assign smask = legacy ? `SPC_STICKY_LEGACY : `SPC_STICKY_NEW;
  assign view = s.ctl & wmask;
  assign seated = !s.cd1_sync[1] && !s.cd2_sync[1];

  // ==========================================
  // Supply request decode
  always_comb begin
    vcc_eff = VCC_OFF;
    vpp_eff = VPP_OFF;
    if (legacy) begin
      // Connect bit picks level from the select input
      if (s.ctl[`SPC_CONNECT_BIT]) begin
        vcc_eff = vcc_voltage_select ? VCC_3V3 : VCC_5V0;
      end
      // Auto switching drops Vcc while the card is not seated
      if (s.ctl[`SPC_AUTO_BIT] && !seated) begin
        vcc_eff = VCC_OFF;
      end
    end else begin
      // Two reserved codes both mean no supply
      unique case (s.ctl[`SPC_VCC_HI:`SPC_VCC_LO])
        `SPC_VCC_5V0: vcc_eff = VCC_5V0;
        `SPC_VCC_3V3: vcc_eff = VCC_3V3;
        default: vcc_eff = VCC_OFF;
      endcase
    end
    // Vpp only counts with Vcc on
    if (vcc_eff != VCC_OFF) begin
      unique case (s.ctl[`SPC_VPP_HI:`SPC_VPP_LO])
        `SPC_VPP_VCC: vpp_eff = legacy ? VPP_VCC : VPP_OFF;
        `SPC_VPP_12V: vpp_eff = VPP_12V;
        default: vpp_eff = VPP_OFF;
      endcase
    end
  end

  // ==========================================
  // Next state
  always_comb begin
    next_s = s;
    // Pins pass two flops before use
    next_s.cd1_sync = {s.cd1_sync[0], cd1_n};
    next_s.cd2_sync = {s.cd2_sync[0], cd2_n};
    // Writes touch only the current layout's bits
    if (reg_wr && hit) begin
      next_s.ctl = (s.ctl & ~wmask) | (reg_wdata & wmask);
    end
    // Bus reset wins over a write in the same cycle
    if (sticky_clr) begin
      next_s.ctl = `SPC_RESET;
    end else if (plain_clr) begin
      next_s.ctl = s.ctl & smask;
    end
    // Read answer one cycle after the strobe, zero when unmapped
    next_s.rvalid = reg_rd;
    next_s.rdata = (reg_rd && hit) ? view : 8'h00;
    // Forward only real changes to the switch
    next_s.sw_vcc = vcc_eff;
    next_s.sw_vpp = vpp_eff;
    next_s.req = (vcc_eff != s.sw_vcc) || (vpp_eff != s.sw_vpp);
  end

  // Single state register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================
  // Outputs
  assign reg_rdata = s.rdata;
  assign reg_rvalid = s.rvalid;
  assign card_output_gate = s.ctl[`SPC_GATE_BIT];
  // Drivers float until the gate opens; the gate bit alone enables them, even with Vcc off
  assign card_drive_oe_n = !s.ctl[`SPC_GATE_BIT];
  assign auto_power_switch_on = legacy && s.ctl[`SPC_AUTO_BIT];
  assign sw_vcc_level = s.sw_vcc;
  assign sw_vpp_level = s.sw_vpp;
  assign power_request = s.req;
  assign card_power_status = (s.sw_vcc != VCC_OFF);

  // ==========================================
  // Assertions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  logic wr_hit; // Clean write to the register
  assign wr_hit = reg_wr && hit && bus_reset_n;

  gate_write_a: assert property (wr_hit |=> card_output_gate == $past(reg_wdata[7]))
    else $error("gate bit did not follow write");
  gate_float_a: assert property (wr_hit && !reg_wdata[7] |=> card_drive_oe_n)
    else $error("card drivers enabled with gate cleared");
  legacy_rsvd_a: assert property (reg_rd && hit && legacy
    |=> reg_rdata[6] == 1'b0 && reg_rdata[3:2] == 2'h0)
    else $error("legacy reserved bits read nonzero");
  new_rsvd_a: assert property (reg_rd && hit && !legacy
    |=> reg_rdata[6:5] == 2'h0 && reg_rdata[2] == 1'b0)
    else $error("new layout reserved bits read nonzero");
  unmapped_read_a: assert property (reg_rd && !hit |=> reg_rvalid && reg_rdata == 8'h00)
    else $error("unmapped read returned data");
  vpp_ignored_a: assert property (sw_vcc_level == VCC_OFF |-> sw_vpp_level == VPP_OFF)
    else $error("Vpp requested without Vcc");
  new_vcc_a: assert property (wr_hit && !legacy && reg_wdata[4:3] == 2'h2 ##1 !legacy && bus_reset_n
    |=> sw_vcc_level == VCC_5V0)
    else $error("new layout 5V code not forwarded");
  legacy_vpp_a: assert property (wr_hit && legacy && reg_wdata == 8'h12 ##1 legacy && bus_reset_n
    |=> sw_vpp_level == VPP_12V && sw_vcc_level != VCC_OFF)
    else $error("legacy 12V request not forwarded");
  auto_drop_a: assert property (legacy && s.ctl[5] && !seated && $stable(compat_revision_field)
    |=> sw_vcc_level == VCC_OFF)
    else $error("Vcc kept with card absent under auto switching");
  request_pulse_a: assert property (power_request == ($changed(sw_vcc_level) || $changed(sw_vpp_level)))
    else $error("power request not tied to a change");
  // Sticky bit must hold through a bus reset while events are enabled
  sticky_keep_a: assert property (plain_clr && pme_enable && legacy && !reg_wr
    |=> s.ctl[5] == $past(s.ctl[5]))
    else $error("sticky bit lost on bus reset");
  // Reserved Vpp code gives no supply in either layout
  vpp_rsvd_off_a: assert property (s.ctl[1:0] == 2'h3 |=> sw_vpp_level == VPP_OFF)
    else $error("reserved Vpp code forwarded a supply");
  // Select input high asks for 3.3V once connected with auto switching off
  legacy_sel_a: assert property (legacy && s.ctl[4] && !s.ctl[5] && vcc_voltage_select
    |=> sw_vcc_level == VCC_3V3)
    else $error("legacy select did not give 3.3V");
  status_track_a: assert property (card_power_status == (sw_vcc_level != VCC_OFF))
    else $error("power status disagrees with Vcc");

  cover_legacy_on_c: cover property (legacy && sw_vcc_level != VCC_OFF && sw_vpp_level == VPP_VCC);
  cover_new_3v3_c: cover property (!legacy && sw_vcc_level == VCC_3V3 && sw_vpp_level == VPP_12V);
  cover_sticky_c: cover property (plain_clr && pme_enable && s.ctl != 8'h00);
  // Detect-driven drop and the legacy 12V request are the other main scenarios
  cover_auto_drop_c: cover property (auto_power_switch_on && !seated && sw_vcc_level == VCC_OFF);
  cover_legacy_12v_c: cover property (legacy && sw_vpp_level == VPP_12V);
endmodule
`default_nettype wire

/* sim/power_switch_model.sv */
// Far-side model: external power switch that counts requests, and a card that drives the detects.
// Assumes power_request is a one-cycle pulse on ref_clk.
`timescale 1ns/100ps
`default_nettype none
module power_switch_model (
  input wire logic ref_clk,
  input wire logic insert,
  input wire logic power_request,
  output logic cd1_n,
  output logic cd2_n,
  output logic [7:0] n_req
);
  // ==========================================
  // Card detects
  // Both detects go low together; a partial insertion is not modelled
  assign cd1_n = !insert;
  assign cd2_n = !insert;

  // ==========================================
  // Power switch request counter
  // Counts pulses so that the bench can spot a missing or a surplus request
  initial n_req = 8'h00;
  always @(posedge ref_clk) begin
    if (power_request === 1'b1) begin
      n_req <= n_req + 8'h01;
    end
  end
endmodule
`default_nettype wire

/* sim/socket_power_control_register_tb.sv */
// Testbench of the socket power control register: both layouts, supply requests and bus resets.
// Assumes the design package, the design and the power switch model are compiled first.
`timescale 1ns/100ps
`default_nettype none
module socket_power_control_register_tb;
  import sock_pwr_pkg::*;
  // ==========================================
  // Stimulus and observed signals
  logic ref_clk = 1, nrst = 1, bus_reset_n = 1, pme_enable = 0;
  logic reg_wr = 0, reg_rd = 0, vcc_voltage_select = 0, insert = 0;
  logic [11:0] reg_addr = 12'h802;
  logic [7:0] reg_wdata = 8'h00;
  logic [3:0] compat_revision_field = 4'h4;
  logic [7:0] reg_rdata, n_req, n0;
  logic reg_rvalid, card_output_gate, card_drive_oe_n, auto_power_switch_on;
  logic power_request, card_power_status, cd1_n, cd2_n;
  vcc_level_t sw_vcc_level;
  vpp_level_t sw_vpp_level;
  int n_errors = 0, check_count = 0;

  socket_power_control_register u_socket_power_control_register (.ref_clk, .nrst, .bus_reset_n,
    .pme_enable, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .reg_rvalid,
    .compat_revision_field, .vcc_voltage_select, .cd1_n, .cd2_n, .card_output_gate,
    .card_drive_oe_n, .auto_power_switch_on, .sw_vcc_level, .sw_vpp_level, .power_request,
    .card_power_status);
  power_switch_model u_power_switch_model (.ref_clk, .insert, .power_request, .cd1_n, .cd2_n,
    .n_req);

  // Clock at 100 MHz; it starts high so that reset falls at a falling edge before the first rising one
  initial begin
    forever #5 ref_clk = !ref_clk;
  end

  // ==========================================
  // Shared tasks
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One-cycle write strobe, inputs moved at the falling edge
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1;
    @(negedge ref_clk);
    reg_wr = 0;
  endtask
  // Answer stands one cycle, so it is sampled at the very next falling edge
  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    @(negedge ref_clk);
    reg_addr = a;
    reg_rd = 1;
    @(negedge ref_clk);
    reg_rd = 0;
    check("rvalid", {7'h00, reg_rvalid}, 8'h01);
    check("rdata", reg_rdata, exp);
  endtask
  // Levels settle one cycle after the register changes
  task automatic lvl(input logic [1:0] v, input logic [1:0] p);
    repeat (2) @(negedge ref_clk);
    check("vcc", {6'h00, sw_vcc_level}, {6'h00, v});
    check("vpp", {6'h00, sw_vpp_level}, {6'h00, p});
  endtask
  task automatic brst();
    @(negedge ref_clk);
    bus_reset_n = 0;
    @(negedge ref_clk);
    bus_reset_n = 1;
  endtask

  // ==========================================
  // Scenarios
  task automatic t_reset();
    check("gate", {7'h00, card_output_gate}, 8'h00);
    check("oe_n", {7'h00, card_drive_oe_n}, 8'h01);
    check("status", {7'h00, card_power_status}, 8'h00);
    rd(12'h802, 8'h00);
  endtask
  task automatic t_new();
    wr(12'h802, 8'hFF);
    rd(12'h802, 8'h9B);
    check("gate", {7'h00, card_output_gate}, 8'h01);
    check("auto", {7'h00, auto_power_switch_on}, 8'h00);
    check("oe_n", {7'h00, card_drive_oe_n}, 8'h00);
    lvl(2'h2, 2'h0);
    for (int i = 0; i < 4; i++) begin
      wr(12'h802, 8'h82 | 8'(i << 3));
      lvl(2'(i < 2 ? 0 : i - 1), i < 2 ? 2'h0 : 2'h2);
    end
    check("status", {7'h00, card_power_status}, 8'h01);
    wr(12'h803, 8'h00);
    rd(12'h802, 8'h9A);
    rd(12'h803, 8'h00);
  endtask
  // An unchanged write must not pulse the switch, a changed one exactly once
  task automatic t_req();
    n0 = n_req;
    wr(12'h802, 8'h9A);
    lvl(2'h2, 2'h2);
    check("requests", n_req, n0);
    wr(12'h802, 8'h92);
    lvl(2'h1, 2'h2);
    check("requests", n_req, n0 + 8'h01);
  endtask
  task automatic t_legacy();
    compat_revision_field = 4'h2;
    wr(12'h802, 8'hFF);
    rd(12'h802, 8'hB3);
    check("auto", {7'h00, auto_power_switch_on}, 8'h01);
    lvl(2'h0, 2'h0);
    insert = 1;
    repeat (5) @(negedge ref_clk);
    lvl(2'h1, 2'h0);
    for (int i = 0; i < 4; i++) begin
      wr(12'h802, 8'h90 | 8'(i));
      lvl(2'h1, i == 3 ? 2'h0 : 2'(i));
    end
    vcc_voltage_select = 1;
    lvl(2'h2, 2'h0);
    wr(12'h802, 8'h12);
    lvl(2'h2, 2'h2);
    check("oe_n", {7'h00, card_drive_oe_n}, 8'h01);
    wr(12'h802, 8'h82);
    lvl(2'h0, 2'h0);
  endtask
  // Sticky bits survive a bus reset only while events are enabled
  task automatic t_bus_reset();
    pme_enable = 1;
    wr(12'h802, 8'hB3);
    brst();
    rd(12'h802, 8'h20);
    pme_enable = 0;
    brst();
    rd(12'h802, 8'h00);
    compat_revision_field = 4'h4;
    pme_enable = 1;
    wr(12'h802, 8'h9B);
    brst();
    rd(12'h802, 8'h9B);
  endtask
  // Global reset clears even sticky bits while events are enabled
  task automatic t_global_reset();
    @(negedge ref_clk);
    nrst = 0;
    repeat (2) @(negedge ref_clk);
    check("gate", {7'h00, card_output_gate}, 8'h00);
    check("status", {7'h00, card_power_status}, 8'h00);
    nrst = 1;
    repeat (3) @(negedge ref_clk);
    rd(12'h802, 8'h00);
  endtask

  // ==========================================
  // Verdict and run control
  task automatic end_of_test();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // The tests take about a hundred and ten cycles; this limit leaves ample margin
  initial begin
    #200000;
    n_errors++;
    end_of_test();
  end
  initial begin
    @(negedge ref_clk);
    nrst = 0;
    repeat (3) @(negedge ref_clk);
    nrst = 1;
    repeat (4) @(negedge ref_clk);
    t_reset();
    t_new();
    t_req();
    t_legacy();
    t_bus_reset();
    t_global_reset();
    end_of_test();
  end
endmodule
`default_nettype wire
